// file: pkg/ppo_pkg.sv
/*
 * Package for the port pin override logic: register offsets, field
 * positions, reset values and the per-pin override carrier.
 * Assumes one 8-pin port behind an AHB-Lite slave with 32-bit data.
 */
package ppo_pkg;
   // ************************************************************
   // Port shape
   // ************************************************************
   localparam int unsigned PINS = 8;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_DIRECTION = 8'h00;
   localparam logic [7:0] OFS_LATCH = 8'h04;
   localparam logic [7:0] OFS_INPUT = 8'h08;
   localparam logic [7:0] OFS_SFIO = 8'h0c;
   localparam logic [7:0] OFS_EXTINT = 8'h10;
   localparam logic [7:0] OFS_EXTFLAG = 8'h14;
   localparam logic [7:0] OFS_SLEEP = 8'h18;

   // ************************************************************
   // Fields and reset values
   // ************************************************************
   localparam int unsigned SFIO_KILL_BIT = 2;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] SFIO_MASK = 8'hff;
   localparam logic [2:0] PULLUP_CODE = 3'b010;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HTRANS_SEQ = 2'b11;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // Sleep controller states (one-hot)
   typedef enum logic [3:0] {
      SLP_RUN = 4'b0001,
      SLP_PDOWN = 4'b0010,
      SLP_PSAVE = 4'b0100,
      SLP_STBY = 4'b1000
   } ppo_sleep_t;

   // Overrides that a peripheral drives for one pin
   typedef struct packed {
      logic pullup_override_enable;
      logic pullup_override_value;
      logic direction_override_enable;
      logic direction_override_value;
      logic drive_value_override_enable;
      logic drive_value_override_value;
      logic input_enable_override_enable;
      logic input_enable_override_value;
   } ppo_ovr_t;

   // Pad controls for one pin
   typedef struct packed {
      logic drive_level;
      logic drive_oe_n;
      logic pullup_on;
      logic input_enable;
   } ppo_pad_t;
endpackage : ppo_pkg

// file: hw/ppo_pin_cell.sv
/*
 * One pin cell: pull-up, driver, drive level and input clamp mux.
 * Assumes overrides come straight from the owning peripheral and the
 * pad value is synchronous to clk.
 */
`timescale 1ns/1ps
module ppo_pin_cell (
   input wire logic pin_direction_bit,
   input wire logic pin_output_latch_bit,
   input wire logic global_pullup_kill,
   input wire logic sleep_clamp,
   input wire logic ext_int_enable,
   input wire logic in_reset,
   input wire ppo_pkg::ppo_ovr_t ovr,
   input wire logic pad_in,
   output ppo_pkg::ppo_pad_t pad,
   output logic schmitt_out
);
   // ************************************************************
   // Pad control muxes
   // ************************************************************
   logic pu_normal;
   logic drv_en;
   logic in_en;

   // Pull-up only for input, latch one, kill clear
   assign pu_normal = ({pin_direction_bit, pin_output_latch_bit,
                        global_pullup_kill} ==
                       ppo_pkg::PULLUP_CODE);
   // Driver enable, overridden per pin
   assign drv_en = ovr.direction_override_enable ?
                   ovr.direction_override_value :
                   pin_direction_bit;
   // Input enable: sleep clamps unless ext interrupt armed
   assign in_en = ovr.input_enable_override_enable ?
                  ovr.input_enable_override_value :
                  (!sleep_clamp || ext_int_enable);

   always_comb begin
      pad.pullup_on = ovr.pullup_override_enable ?
                      ovr.pullup_override_value : pu_normal;
      pad.drive_oe_n = !drv_en;
      pad.drive_level = ovr.drive_value_override_enable ?
                        ovr.drive_value_override_value :
                        pin_output_latch_bit;
      pad.input_enable = in_en;
      // Reset wins over the pull-up and driver enable, overrides included: tri-state, no pull-up
      if (in_reset) begin
         pad.pullup_on = 1'b0;
         pad.drive_oe_n = 1'b1;
      end
   end

   // Clamp to ground ahead of the Schmitt trigger
   assign schmitt_out = pad_in & in_en;
endmodule : ppo_pin_cell

// file: hw/ppo_port.sv
/*
 * Eight-pin general purpose port with peripheral overrides, sleep
 * clamping, global pull-up kill and an AHB-Lite register slave.
 * Assumes a single AHB-Lite master and pad inputs synchronous to clk.
 */
`timescale 1ns/1ps
module ppo_port (
   input wire logic clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Sleep controller
   input wire ppo_pkg::ppo_sleep_t sleep_state,
   // Peripheral side
   input wire ppo_pkg::ppo_ovr_t [7:0] ovr,
   output logic [7:0] alt_function_pin_sample,
   // Pads
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe_n,
   output logic [7:0] pad_pullup,
   output logic [7:0] pad_input_enable,
   // Analog tap, pad-level signal split into its three parts
   input wire logic [7:0] analog_pad_tap_in,
   output logic [7:0] analog_pad_tap_out,
   output logic [7:0] analog_pad_tap_oe_n,
   input wire logic [7:0] analog_drive_oe_n,
   input wire logic [7:0] analog_drive_val
);
   // ************************************************************
   // Register state
   // ************************************************************
   logic [7:0] dir_q;
   logic [7:0] latch_q;
   logic [7:0] sfio_q;
   logic [7:0] extint_en_q;
   logic [7:0] edge_mode_q;
   logic [7:0] flag_q;
   logic [7:0] flag_d;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] schmitt;
   logic global_pullup_kill;
   logic sleep_clamp;
   logic was_clamped_q;
   logic in_reset;

   // ************************************************************
   // Bus slave
   // ************************************************************
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] addr_q;
   logic addr_ok;
   logic req;

   // Exact 8-bit address compare used by both read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   assign req = hsel && hready &&
                (htrans == ppo_pkg::HTRANS_NONSEQ ||
                 htrans == ppo_pkg::HTRANS_SEQ);
   assign addr_ok = 1'b1;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign in_reset = !rstn;

   // Latch the address phase
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= ppo_pkg::RST_BYTE;
      end else begin
         wr_pend_q <= req && hwrite && addr_ok;
         rd_pend_q <= req && !hwrite;
         if (req) begin
            addr_q <= haddr;
         end
      end
   end

   // Write strobes shared by all pins of the port
   always_ff @(posedge clk) begin
      if (!rstn) begin
         dir_q <= ppo_pkg::RST_BYTE;
         latch_q <= ppo_pkg::RST_BYTE;
         sfio_q <= ppo_pkg::RST_BYTE;
         extint_en_q <= ppo_pkg::RST_BYTE;
         edge_mode_q <= ppo_pkg::RST_BYTE;
      end else if (wr_pend_q) begin
         if (hit(addr_q, ppo_pkg::OFS_DIRECTION)) begin
            dir_q <= hwdata[7:0];
         end
         if (hit(addr_q, ppo_pkg::OFS_LATCH)) begin
            latch_q <= hwdata[7:0];
         end
         if (hit(addr_q, ppo_pkg::OFS_SFIO)) begin
            sfio_q <= hwdata[7:0] & ppo_pkg::SFIO_MASK;
         end
         if (hit(addr_q, ppo_pkg::OFS_EXTINT)) begin
            extint_en_q <= hwdata[7:0];
            edge_mode_q <= hwdata[15:8];
         end
      end
   end

   // Read mux, registered; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hrdata <= ppo_pkg::RDATA_ZERO;
      end else if (req && !hwrite) begin
         unique case (1'b1)
            hit(haddr, ppo_pkg::OFS_DIRECTION): hrdata <= {24'h0, dir_q};
            hit(haddr, ppo_pkg::OFS_LATCH): hrdata <= {24'h0, latch_q};
            hit(haddr, ppo_pkg::OFS_INPUT): hrdata <= {24'h0, sync2_q};
            hit(haddr, ppo_pkg::OFS_SFIO): hrdata <= {24'h0, sfio_q};
            hit(haddr, ppo_pkg::OFS_EXTINT):
               hrdata <= {16'h0, edge_mode_q, extint_en_q};
            hit(haddr, ppo_pkg::OFS_EXTFLAG): hrdata <= {24'h0, flag_q};
            hit(haddr, ppo_pkg::OFS_SLEEP):
               hrdata <= {28'h0, sleep_state};
            default: hrdata <= ppo_pkg::RDATA_ZERO;
         endcase
      end
   end

   // ************************************************************
   // Shared controls
   // ************************************************************
   assign global_pullup_kill = sfio_q[ppo_pkg::SFIO_KILL_BIT];
   // Power-down, power-save and standby clamp; run does not
   assign sleep_clamp = (sleep_state != ppo_pkg::SLP_RUN);

   // ************************************************************
   // Pin cells
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < ppo_pkg::PINS; g++) begin : gen_pin
         ppo_pkg::ppo_pad_t pad;
         ppo_pin_cell u_cell (
            .pin_direction_bit(dir_q[g]),
            .pin_output_latch_bit(latch_q[g]),
            .global_pullup_kill(global_pullup_kill),
            .sleep_clamp(sleep_clamp),
            .ext_int_enable(extint_en_q[g]),
            .in_reset(in_reset),
            .ovr(ovr[g]),
            .pad_in(pad_in[g]),
            .pad(pad),
            .schmitt_out(schmitt[g])
         );
         assign pad_out[g] = pad.drive_level;
         assign pad_oe_n[g] = pad.drive_oe_n;
         assign pad_pullup[g] = pad.pullup_on;
         assign pad_input_enable[g] = pad.input_enable;
      end
   endgenerate

   // Unsynchronised tap; the peripheral synchronises it itself
   assign alt_function_pin_sample = schmitt;
   // Analog tap passes drive value and enable straight out; analog_pad_tap_in is unused
   assign analog_pad_tap_out = analog_drive_val;
   assign analog_pad_tap_oe_n = analog_drive_oe_n;

   // ************************************************************
   // Input synchroniser
   // ************************************************************
   // Two stages: a value software just drove is seen two cycles late
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync1_q <= ppo_pkg::RST_BYTE;
         sync2_q <= ppo_pkg::RST_BYTE;
      end else begin
         sync1_q <= schmitt;
         sync2_q <= sync1_q;
      end
   end

   // ************************************************************
   // Wake flags
   // ************************************************************
   // Clamp releasing a high disabled edge pin is a real edge
   always_comb begin
      flag_d = flag_q;
      if (wr_pend_q && hit(addr_q, ppo_pkg::OFS_EXTFLAG)) begin
         flag_d = flag_q & ~hwdata[7:0];
      end
      if (was_clamped_q && !sleep_clamp) begin
         // Set after clear so an event in the clear cycle survives
         flag_d = flag_d | (edge_mode_q & ~extint_en_q & sync2_q
                  | edge_mode_q & ~extint_en_q & pad_in);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         flag_q <= ppo_pkg::RST_BYTE;
         was_clamped_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         was_clamped_q <= sleep_clamp;
      end
   end
endmodule : ppo_port

// file: tb/ppo_pad_env.sv
/* Pad environment: outside circuitry on the eight pins.
   Assumes pad controls come straight from ppo_port. */
`timescale 1ns/1ps
module ppo_pad_env (
   input wire logic clk,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe_n,
   input wire logic [7:0] pad_pullup,
   input wire logic [7:0] ext_drive,
   input wire logic [7:0] ext_level,
   output logic [7:0] pad_in
);
   logic [7:0] float_q = 8'h55;
   // Undriven pins wander, so a float never reads as a steady level
   always_ff @(posedge clk) begin
      float_q <= ~float_q;
   end
   // Chip driver first, then outside driver, then pull-up holds the pin
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_drive & ext_level)
      | (pad_oe_n & ~ext_drive & (pad_pullup | float_q));
endmodule : ppo_pad_env

// file: tb/ppo_port_chk.sv
/* Checker for the pin override logic, bound to ppo_port.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
module ppo_port_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire ppo_pkg::ppo_sleep_t sleep_state,
   input wire ppo_pkg::ppo_ovr_t [7:0] ovr,
   input wire logic [7:0] alt_function_pin_sample,
   input wire logic [7:0] pad_in,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe_n,
   input wire logic [7:0] pad_pullup,
   input wire logic [7:0] pad_input_enable,
   input wire logic [7:0] analog_pad_tap_out,
   input wire logic [7:0] analog_pad_tap_oe_n,
   input wire logic [7:0] analog_drive_oe_n,
   input wire logic [7:0] analog_drive_val
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Reset must quiet the pins, so this one is never disabled
   chk_rst_quiet: assert property (disable iff (1'b0)
      !rstn |-> pad_oe_n == 8'hff && pad_pullup == 8'h00)
      else $error("pins not quiet in reset");
   chk_bus_okay: assert property (
      hreadyout && !hresp) else $error("bus answer not okay");
   chk_alt_tap: assert property (
      alt_function_pin_sample == (pad_in & pad_input_enable))
      else $error("alt sample not taken before sync");
   chk_analog_pass: assert property (
      analog_pad_tap_out == analog_drive_val
      && analog_pad_tap_oe_n == analog_drive_oe_n)
      else $error("analog tap not straight");
   // Per-pin override relations
   for (genvar g = 0; g < 8; g++) begin : g_pin
      wire ppo_pkg::ppo_ovr_t o = ovr[g];
      chk_pull_ovr: assert property (
         o.pullup_override_enable
         |-> pad_pullup[g] == o.pullup_override_value)
         else $error("pull-up ignores override");
      chk_pull_drv: assert property (
         !o.pullup_override_enable && !o.direction_override_enable
         && !pad_oe_n[g] |-> !pad_pullup[g])
         else $error("pull-up on a driven pin");
      chk_dir_ovr: assert property (
         o.direction_override_enable
         |-> pad_oe_n[g] == !o.direction_override_value)
         else $error("driver ignores override");
      chk_val_ovr: assert property (
         o.drive_value_override_enable
         |-> pad_out[g] == o.drive_value_override_value)
         else $error("level ignores override");
      chk_in_ovr: assert property (
         o.input_enable_override_enable
         |-> pad_input_enable[g] == o.input_enable_override_value)
         else $error("input enable ignores override");
      chk_in_run: assert property (
         !o.input_enable_override_enable
         && sleep_state == ppo_pkg::SLP_RUN |-> pad_input_enable[g])
         else $error("input off while running");
   end
endmodule : ppo_port_chk

// file: tb/tb_ppo_port.sv
/* Testbench for ppo_port: bus tasks, pad environment, scenarios.
   Assumes a zero-wait slave and the checker bound below. */
`timescale 1ns/1ps
module tb_ppo_port;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic hready, hreadyout, hresp;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] haddr = 8'h00;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   ppo_pkg::ppo_sleep_t sleep_state = ppo_pkg::SLP_RUN;
   ppo_pkg::ppo_ovr_t [7:0] ovr = 64'h0;
   logic [7:0] ext_drive = 8'h00, ext_level = 8'h00;
   logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup, pad_input_enable;
   logic [7:0] alt_function_pin_sample;
   logic [7:0] analog_pad_tap_out, analog_pad_tap_oe_n;
   logic [7:0] analog_drive_oe_n = 8'hff, analog_drive_val = 8'h00;
   int err_count = 0, compares = 0;
   assign hready = hreadyout;
   ppo_port dut (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .sleep_state, .ovr,
      .alt_function_pin_sample, .pad_in, .pad_out, .pad_oe_n, .pad_pullup,
      .pad_input_enable, .analog_pad_tap_in(pad_in), .analog_pad_tap_out,
      .analog_pad_tap_oe_n, .analog_drive_oe_n, .analog_drive_val);
   ppo_pad_env env (.clk, .pad_out, .pad_oe_n, .pad_pullup, .ext_drive,
      .ext_level, .pad_in);
   initial forever #50 clk = ~clk;
   task automatic end_sim;
      $display("Compares %0d, errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   task automatic cmp(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // One single-word transfer; the wait ends only on hready
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= ppo_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic settle;
      @(posedge clk);
      #10;
   endtask : settle
   task automatic t_reset;
      logic [7:0] a[3] = '{8'h00, 8'h04, 8'h0c};
      // Pins 0-3 drive high, 4-7 pulled up, so reset has work to undo
      bus(1'b1, 8'h00, 32'h0f);
      bus(1'b1, 8'h04, 32'hff);
      bus(1'b1, 8'h0c, 32'h01);
      settle;
      cmp("pullup", 8'hf0, pad_pullup);
      cmp("oe_n", 8'hf0, pad_oe_n);
      @(posedge clk);
      rstn <= 1'b0;
      #10;
      cmp("pullup", 8'h00, pad_pullup);
      cmp("oe_n", 8'hff, pad_oe_n);
      @(posedge clk);
      rstn <= 1'b1;
      foreach (a[i]) begin
         bus(1'b0, a[i], 32'h0);
         cmp("reg", 32'h0, rd);
      end
   endtask : t_reset
   task automatic t_gpio;
      bus(1'b1, 8'h00, 32'h0f);
      bus(1'b1, 8'h04, 32'hf3);
      settle;
      cmp("oe_n", 8'hf0, pad_oe_n);
      cmp("out", 8'hf3, pad_out);
      cmp("pullup", 8'hf0, pad_pullup);
      bus(1'b1, 8'h0c, 32'h04);
      settle;
      cmp("pullup", 8'h00, pad_pullup);
   endtask : t_gpio
   // Pin i: pull-up and input from bit 0, driver bit 1, level bit 2
   task automatic t_ovr;
      @(posedge clk);
      for (int i = 0; i < 8; i++)
         ovr[i] <= {1'b1, i[0], 1'b1, i[1], 1'b1, i[2], 1'b1, i[0]};
      sleep_state <= ppo_pkg::SLP_PDOWN;
      #10;
      cmp("pullup", 8'haa, pad_pullup);
      cmp("oe_n", 8'h33, pad_oe_n);
      cmp("out", 8'hf0, pad_out);
      cmp("in_en", 8'haa, pad_input_enable);
      @(posedge clk);
      ovr <= 64'h0;
      sleep_state <= ppo_pkg::SLP_RUN;
      bus(1'b1, 8'h0c, 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h04, 32'h0);
   endtask : t_ovr
   task automatic t_input;
      @(posedge clk);
      ext_drive <= 8'hff;
      ext_level <= 8'ha5;
      analog_drive_val <= 8'h3c;
      analog_drive_oe_n <= 8'hc3;
      #10;
      cmp("alt", 8'ha5, alt_function_pin_sample);
      cmp("tap", 16'hc33c,
          {analog_pad_tap_oe_n, analog_pad_tap_out});
      // Both synchroniser stages must fill before the pin register reads
      repeat (2) @(posedge clk);
      bus(1'b0, 8'h08, 32'h0);
      cmp("input", 32'ha5, rd);
   endtask : t_input
   task automatic t_sleep;
      ppo_pkg::ppo_sleep_t deep[3] = '{ppo_pkg::SLP_PDOWN, ppo_pkg::SLP_PSAVE,
         ppo_pkg::SLP_STBY};
      ext_level <= 8'hff;
      bus(1'b1, 8'h10, 32'h0201);
      foreach (deep[i]) begin
         @(posedge clk);
         sleep_state <= deep[i];
         #10;
         cmp("in_en", 8'h01, pad_input_enable);
      end
      @(posedge clk);
      sleep_state <= ppo_pkg::SLP_RUN;
      #10;
      cmp("in_en", 8'hff, pad_input_enable);
      bus(1'b0, 8'h14, 32'h0);
      cmp("flags", 32'h2, rd);
      bus(1'b1, 8'h14, 32'h2);
      bus(1'b0, 8'h14, 32'h0);
      cmp("flags", 32'h0, rd);
      bus(1'b0, 8'h1c, 32'h0);
      cmp("unmapped", 32'h0, rd);
      bus(1'b0, 8'h18, 32'h0);
      cmp("sleep", 32'h1, rd);
   endtask : t_sleep
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_gpio;
      t_ovr;
      t_input;
      t_sleep;
      end_sim;
   end
   // Watchdog: the whole run needs about ninety cycles
   initial begin
      #1000000;
      err_count++;
      end_sim;
   end
endmodule : tb_ppo_port
bind ppo_port ppo_port_chk u_chk (.clk, .rstn, .hreadyout, .hresp,
   .sleep_state, .ovr, .alt_function_pin_sample, .pad_in, .pad_out,
   .pad_oe_n, .pad_pullup,
   .pad_input_enable, .analog_pad_tap_out, .analog_pad_tap_oe_n,
   .analog_drive_oe_n, .analog_drive_val);
